/* src/wkd_top.sv */
// Contract
// R1 - mask bit j includes byte offset plus j
// R2 - command bit 3 picks multicast or unicast
// R3 - command bit 0 enables filter
// R4 - eight-bit offset starts crc checking
// R5 - software keeps offsets at twelve or more
// R6 - position zero is first destination byte
// R7 - crc-16 match flags pattern wake frame
// R8 - sequence enable starts sequence scanning
// R9 - sequence mode suppresses ordinary reception
// R10 - notify by interrupt or power event
// R11 - detection sets sequence seen flag
// R12 - clearing enable restores ordinary reception
// R13 - sync ones then sixteen address copies
// R14 - multicast frames accepted for sequences
// R15 - light sleep forces both detectors on
// R16 - pattern enable suppresses ordinary reception
// R17 - pattern detection sets pattern seen flag
// R18 - software loads table by eight writes
// R19 - broadcast pattern wakes despite block bit
// R20 - seen flags stay until software clears
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "wkd_map.svh"

module wkd_top
    import wkd_pkg::*;
#(
    parameter int FILTERS = 4
) (
    input wire logic core_clk_i, // 10 MHz clock
    input wire logic nrst_i, // async reset
    input wire logic ce_i, // clock enable
    input wire logic [7:0] reg_addr_i, // register byte address
    input wire wkd_word_t reg_wdata_i, // write data
    input wire logic reg_wr_i, // write strobe
    input wire logic reg_rd_i, // read strobe
    output wkd_word_t reg_rdata_o, // read data, next cycle
    input wire logic rx_valid_i, // receive byte valid
    input wire wkd_rx_s rx_beat_i, // receive byte and marks
    input wire logic [47:0] station_addr_i, // own address
    input wire logic light_sleep_i, // light sleep state
    output logic host_irq_o, // wake to host interrupt
    output logic power_event_o, // wake to power event
    output logic rx_suppress_o // ordinary reception off
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                             input logic [2:0] k);
        logic [7:0] r;
        r = a[47:40];
        case (k)
            3'h1: r = a[39:32];
            3'h2: r = a[31:24];
            3'h3: r = a[23:16];
            3'h4: r = a[15:8];
            3'h5: r = a[7:0];
            default: r = a[47:40];
        endcase
        return r;
    endfunction

    function automatic wkd_word_t keep_bits(input logic [2:0] idx);
        wkd_word_t r;
        r = `WKD_FULL_KEEP;
        if (idx < `WKD_CMD_WORD) begin
            r = `WKD_MASK_KEEP;
        end else if (idx == `WKD_CMD_WORD) begin
            r = `WKD_CMD_KEEP;
        end
        return r;
    endfunction

    // ****************************************
    // register port
    // ****************************************
    wkd_word_t words [0:7];
    logic [2:0] tbl_ptr;
    logic seq_en;
    logic pat_en;
    logic note_pme;
    logic seq_seen;
    logic pat_seen;
    logic seq_hit;
    logic pat_hit;
    logic tbl_sel;
    logic wcs_sel;
    logic wcs_wr;
    wkd_word_t wcs_val;

    assign tbl_sel = reg_addr_i == `WKD_TABLE_OFS;
    assign wcs_sel = reg_addr_i == `WKD_WCS_OFS;
    assign wcs_wr = ce_i && reg_wr_i && wcs_sel;

    always_comb begin
        wcs_val = '0;
        wcs_val[`WKD_WCS_SEQ_EN] = seq_en;
        wcs_val[`WKD_WCS_PAT_EN] = pat_en;
        wcs_val[`WKD_WCS_NOTE_PME] = note_pme;
        wcs_val[`WKD_WCS_SEQ_SEEN] = seq_seen;
        wcs_val[`WKD_WCS_PAT_SEEN] = pat_seen;
    end

    // table is walked by one pointer; reads also step it
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tbl_ptr <= '0;
            for (int w = 0; w < 8; w++) begin
                words[w] <= '0;
            end
        end else if (ce_i && tbl_sel && (reg_wr_i || reg_rd_i)) begin
            if (reg_wr_i) begin
                words[tbl_ptr] <= reg_wdata_i & keep_bits(tbl_ptr); // R1 R18
            end
            tbl_ptr <= tbl_ptr + 3'h1; // R18
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            if (reg_rd_i && tbl_sel) begin
                reg_rdata_o <= words[tbl_ptr];
            end else if (reg_rd_i && wcs_sel) begin
                reg_rdata_o <= wcs_val;
            end else begin
                reg_rdata_o <= '0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seq_en <= 1'b0;
            pat_en <= 1'b0;
            note_pme <= 1'b0;
        end else if (wcs_wr) begin
            seq_en <= reg_wdata_i[`WKD_WCS_SEQ_EN]; // R8 R12
            pat_en <= reg_wdata_i[`WKD_WCS_PAT_EN]; // R16
            note_pme <= reg_wdata_i[`WKD_WCS_NOTE_PME]; // R10
        end
    end

    // seen flags: set beats a same-cycle write-one clear
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seq_seen <= 1'b0;
            pat_seen <= 1'b0;
        end else if (ce_i) begin
            if (seq_hit) begin
                seq_seen <= 1'b1; // R11
            end else if (wcs_wr && reg_wdata_i[`WKD_WCS_SEQ_SEEN]) begin
                seq_seen <= 1'b0; // R20
            end
            if (pat_hit) begin
                pat_seen <= 1'b1; // R17
            end else if (wcs_wr && reg_wdata_i[`WKD_WCS_PAT_SEEN]) begin
                pat_seen <= 1'b0; // R20
            end
        end
    end

    // ****************************************
    // modes and notification
    // ****************************************
    logic seq_active;
    logic pat_active;
    logic mode_on;
    assign seq_active = seq_en || light_sleep_i; // R8 R15
    assign pat_active = pat_en || light_sleep_i; // R15 R16
    assign mode_on = seq_active || pat_active;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_suppress_o <= 1'b0;
            host_irq_o <= 1'b0;
            power_event_o <= 1'b0;
        end else if (ce_i) begin
            rx_suppress_o <= mode_on; // R9 R12 R16
            host_irq_o <= !note_pme && (seq_seen || pat_seen); // R10
            power_event_o <= note_pme && (seq_seen || pat_seen); // R10
        end
    end

    // ****************************************
    // frame position and destination
    // ****************************************
    logic beat;
    logic [7:0] rxd;
    logic [8:0] byte_pos;
    logic [8:0] cur_pos;
    logic mcast;
    logic da_ok;
    logic eval_pend;
    assign beat = ce_i && rx_valid_i;
    assign rxd = rx_beat_i.data;
    assign cur_pos = rx_beat_i.sof ? 9'h000 : byte_pos; // R6

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            byte_pos <= '0;
            mcast <= 1'b0;
            da_ok <= 1'b0;
            eval_pend <= 1'b0;
        end else if (ce_i) begin
            eval_pend <= beat && rx_beat_i.eof && pat_active;
            if (beat) begin
                if (cur_pos != `WKD_POS_MAX) begin
                    byte_pos <= cur_pos + 9'h001;
                end
                if (rx_beat_i.sof) begin
                    mcast <= rxd[0];
                end
                if (cur_pos < `WKD_DA_LEN) begin
                    da_ok <= (rx_beat_i.sof || da_ok) &&
                        rxd == addr_byte(station_addr_i, cur_pos[2:0]);
                end
            end
        end
    end

    // ****************************************
    // pattern filters
    // ****************************************
    logic [FILTERS-1:0] match;

    for (genvar i = 0; i < FILTERS; i++) begin : g_filt
        localparam int CW = int'(`WKD_CRC_WORD) + i / 2;
        logic [30:0] f_mask;
        logic [3:0] f_cmd;
        logic [7:0] f_off;
        logic [15:0] f_crc;
        logic [15:0] crc_q;
        logic [8:0] diff;
        logic take;
        logic type_ok;
        assign f_mask = words[i][30:0];
        assign f_cmd = words[`WKD_CMD_WORD][8*i +: 4];
        assign f_off = words[`WKD_OFS_WORD][8*i +: 8]; // R4
        assign f_crc = words[CW][16*(i%2) +: 16];
        assign diff = cur_pos - {1'b0, f_off};
        assign take = cur_pos >= {1'b0, f_off} &&
            diff < `WKD_MASK_LEN && f_mask[diff[4:0]]; // R1 R4

        wkd_crc16 u_crc (
            .core_clk_i(core_clk_i),
            .nrst_i(nrst_i),
            .ce_i(ce_i),
            .clr_i(beat && rx_beat_i.sof),
            .en_i(beat && take && pat_active),
            .data_i(rxd),
            .crc_o(crc_q)
        );

        // broadcast counts as multicast; block bit not consulted
        assign type_ok = f_cmd[`WKD_CMD_MCAST] ? mcast : // R2 R19
            (!mcast && da_ok);
        assign match[i] = f_cmd[`WKD_CMD_ENABLE] && type_ok && // R3
            crc_q == f_crc; // R7
    end

    assign pat_hit = ce_i && eval_pend && (|match); // R7

    // ****************************************
    // sequence detector
    // ****************************************
    wkd_seq_e st;
    wkd_seq_e next_st;
    logic [2:0] ones;
    logic [2:0] next_ones;
    logic [2:0] bsel;
    logic [2:0] next_bsel;
    logic [3:0] rep;
    logic [3:0] next_rep;
    logic next_hit;
    logic is_ones;
    logic is_addr;

    assign is_ones = rxd == `WKD_ONES;

    always_comb begin
        next_st = rx_beat_i.sof ? SEQ_HUNT : st;
        next_ones = rx_beat_i.sof ? 3'h0 : ones;
        next_bsel = bsel;
        next_rep = rep;
        next_hit = 1'b0;
        is_addr = rxd == addr_byte(station_addr_i, bsel);
        case (next_st)
            SEQ_HUNT: begin
                if (!is_ones) begin
                    next_ones = 3'h0;
                end else if (next_ones + 3'h1 == `WKD_SYNC_LEN) begin
                    next_st = SEQ_SYNC; // R13
                end else begin
                    next_ones = next_ones + 3'h1;
                end
            end
            SEQ_SYNC: begin
                next_bsel = 3'h1;
                next_rep = 4'h0;
                if (rxd == addr_byte(station_addr_i, 3'h0)) begin
                    next_st = SEQ_ADDR; // R13
                end else if (!is_ones) begin
                    next_st = SEQ_HUNT;
                    next_ones = 3'h0;
                end
            end
            SEQ_ADDR: begin
                if (!is_addr) begin
                    next_st = SEQ_HUNT;
                    next_ones = is_ones ? 3'h1 : 3'h0;
                end else if (bsel != `WKD_ADDR_LAST_BYTE) begin
                    next_bsel = bsel + 3'h1;
                end else if (rep == `WKD_ADDR_LAST_REP) begin
                    next_hit = 1'b1; // R13 R14
                    next_st = SEQ_HUNT;
                    next_ones = 3'h0;
                end else begin
                    next_bsel = 3'h0;
                    next_rep = rep + 4'h1;
                end
            end
            default: begin
                next_st = SEQ_HUNT;
                next_ones = 3'h0;
            end
        endcase
    end

    // any destination type is scanned
    assign seq_hit = beat && seq_active && next_hit; // R14

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= SEQ_HUNT;
            ones <= '0;
            bsel <= '0;
            rep <= '0;
        end else if (ce_i && !seq_active) begin
            st <= SEQ_HUNT; // R8 R12
            ones <= '0;
        end else if (beat) begin
            st <= next_st;
            ones <= next_ones;
            bsel <= next_bsel;
            rep <= next_rep;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_rd_wcs;
        ce_i && reg_rd_i && wcs_sel;
    endsequence

    sequence s_seq_done;
        st == SEQ_ADDR && rep == `WKD_ADDR_LAST_REP &&
            bsel == `WKD_ADDR_LAST_BYTE;
    endsequence

    a_seq_seen_set: assert property (seq_hit |=> seq_seen) // R11
        else $error("sequence seen flag not set");
    a_pat_seen_set: assert property (pat_hit |=> pat_seen) // R17
        else $error("pattern seen flag not set");
    a_seen_sticky: assert property ( // R20
        seq_seen && !wcs_wr |=> seq_seen)
        else $error("sequence seen flag lost");
    a_suppress_mode: assert property ( // R9
        ce_i |=> rx_suppress_o == $past(mode_on))
        else $error("suppress does not follow mode");
    a_irq_route: assert property ( // R10
        ce_i && seq_seen && !note_pme |=> host_irq_o && !power_event_o)
        else $error("wake not routed to interrupt");
    a_mask_top: assert property ( // R1
        !(words[0][`WKD_MASK_TOP] || words[1][`WKD_MASK_TOP] ||
          words[2][`WKD_MASK_TOP] || words[3][`WKD_MASK_TOP]))
        else $error("mask bit 31 not zero");
    a_seq_needs_run: assert property (seq_hit |-> s_seq_done) // R13
        else $error("sequence hit without full run");
    a_read_status: assert property ( // R11
        s_rd_wcs |=> reg_rdata_o[`WKD_WCS_SEQ_SEEN] == $past(seq_seen))
        else $error("status read mismatch");
    a_idle_hunt: assert property ( // R15
        ce_i && !seq_active |=> st == SEQ_HUNT && !seq_hit)
        else $error("scanner active while disabled");

endmodule

/* src/wkd_map.svh */
`ifndef WKD_MAP_SVH
`define WKD_MAP_SVH

// ****************************************
// register map
// ****************************************
`define WKD_TABLE_OFS 8'h00
`define WKD_WCS_OFS 8'h04
`define WKD_WCS_SEQ_EN 0
`define WKD_WCS_PAT_EN 1
`define WKD_WCS_NOTE_PME 2
`define WKD_WCS_SEQ_SEEN 4
`define WKD_WCS_PAT_SEEN 5

// ****************************************
// filter table layout
// ****************************************
`define WKD_MASK_KEEP 32'h7FFFFFFF
`define WKD_CMD_KEEP 32'h0F0F0F0F
`define WKD_FULL_KEEP 32'hFFFFFFFF
`define WKD_MASK_TOP 31
`define WKD_CMD_WORD 3'h4
`define WKD_OFS_WORD 3'h5
`define WKD_CRC_WORD 3'h6
`define WKD_CMD_ENABLE 0
`define WKD_CMD_MCAST 3
`define WKD_MASK_LEN 9'h01F

// ****************************************
// frame scanning
// ****************************************
`define WKD_POS_MAX 9'h1FF
`define WKD_DA_LEN 9'h006
`define WKD_SYNC_LEN 3'h6
`define WKD_ONES 8'hFF
`define WKD_ADDR_LAST_BYTE 3'h5
`define WKD_ADDR_LAST_REP 4'hF
`define WKD_CRC_POLY 16'hA001
`define WKD_CRC_INIT 16'hFFFF

`endif

/* src/wkd_pkg.sv */
package wkd_pkg;

    typedef struct packed {
        logic sof;
        logic eof;
        logic [7:0] data;
    } wkd_rx_s;

    typedef enum logic [1:0] {
        SEQ_HUNT = 2'b00,
        SEQ_SYNC = 2'b01,
        SEQ_ADDR = 2'b11
    } wkd_seq_e;

    typedef logic [31:0] wkd_word_t;

endpackage

/* src/wkd_crc16.sv */
`timescale 1ns/1ns
`include "wkd_map.svh"

module wkd_crc16 (
    input wire logic core_clk_i, // clock
    input wire logic nrst_i, // async reset
    input wire logic ce_i, // clock enable
    input wire logic clr_i, // restart at frame start
    input wire logic en_i, // fold in this byte
    input wire logic [7:0] data_i, // frame byte
    output logic [15:0] crc_o // running crc
);

    // ****************************************
    // one byte, lsb first
    // ****************************************
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 0; b < 8; b++) begin
            if (r[0] ^ d[b]) begin
                r = (r >> 1) ^ `WKD_CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    logic [15:0] base;
    assign base = clr_i ? `WKD_CRC_INIT : crc_o;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            crc_o <= `WKD_CRC_INIT;
        end else if (ce_i && en_i) begin
            crc_o <= crc_step(base, data_i);
        end else if (ce_i && clr_i) begin
            crc_o <= `WKD_CRC_INIT;
        end
    end

endmodule

/* tb/wkd_station.sv */
`timescale 1ns/1ns

module wkd_station
    import wkd_pkg::*;
(
    input wire logic core_clk_i, // bench clock
    output logic rx_valid_o, // byte valid
    output wkd_rx_s rx_beat_o // byte and frame marks
);
    // ****************************************
    // frame sender
    // ****************************************
    logic busy = 1'b0;

    initial begin
        rx_valid_o = 1'b0;
        rx_beat_o = '{sof: 1'b0, eof: 1'b0, data: 8'h5A};
    end

    // idle line carries junk that changes every cycle
    always @(posedge core_clk_i) begin
        if (!busy) begin
            rx_beat_o.data <= ~rx_beat_o.data;
        end
    end

    task automatic send(input logic [7:0] f[$]);
        busy = 1'b1;
        for (int i = 0; i < f.size(); i++) begin
            @(posedge core_clk_i);
            rx_valid_o <= 1'b1;
            rx_beat_o <= '{sof: (i == 0), eof: (i == f.size() - 1),
                           data: f[i]};
        end
        @(posedge core_clk_i);
        rx_valid_o <= 1'b0;
        rx_beat_o <= '{sof: 1'b0, eof: 1'b0, data: ~f[f.size() - 1]};
        busy = 1'b0;
    endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns

module tb_top;
    import wkd_pkg::*;

    localparam logic [47:0] STA = 48'h021122334455;
    localparam logic [47:0] MCA = 48'h01005E000001;

    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    wkd_word_t reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wkd_word_t reg_rdata;
    logic rx_valid;
    wkd_rx_s rx_beat;
    logic light_sleep = 1'b0;
    logic ce = 1'b1;
    logic host_irq;
    logic power_event;
    logic rx_suppress;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] fr[$];
    wkd_word_t tbl[8];

    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end

    wkd_top dut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .rx_valid_i(rx_valid), .rx_beat_i(rx_beat),
        .station_addr_i(STA), .light_sleep_i(light_sleep),
        .host_irq_o(host_irq), .power_event_o(power_event),
        .rx_suppress_o(rx_suppress)
    );

    wkd_station st (
        .core_clk_i(core_clk_i), .rx_valid_o(rx_valid), .rx_beat_o(rx_beat)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic complete_run();
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input wkd_word_t d);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input wkd_word_t exp);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic load_tbl();
        for (int i = 0; i < 8; i++) wr(8'h00, tbl[i]);
    endtask

    task automatic outs(input logic [2:0] exp);
        repeat (4) @(posedge core_clk_i);
        #1;
        chk({29'h0, host_irq, power_event, rx_suppress}, {29'h0, exp});
    endtask

    function automatic logic [15:0] crc_of(input logic [7:0] f[$],
                                           input int ofs,
                                           input logic [30:0] m);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int j = 0; j < 31; j++) begin
            if (m[j]) begin
                c = c ^ {8'h00, f[ofs + j]};
                repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        return c;
    endfunction

    task automatic mk_pat(input logic [47:0] da, input logic [7:0] b14);
        fr = {};
        for (int i = 5; i >= 0; i--) fr.push_back(da[8*i +: 8]);
        for (int i = 0; i < 14; i++) fr.push_back(8'h10 + 8'(i));
        fr[12] = 8'h3C;
        fr[14] = b14;
    endtask

    task automatic mk_seq(input int reps);
        fr = {};
        for (int i = 5; i >= 0; i--) fr.push_back(MCA[8*i +: 8]);
        for (int i = 0; i < 6; i++) fr.push_back(8'h66);
        for (int i = 0; i < 6; i++) fr.push_back(8'hFF);
        for (int r = 0; r < reps; r++) begin
            for (int i = 5; i >= 0; i--) fr.push_back(STA[8*i +: 8]);
        end
        fr.push_back(8'h00);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk(8'h04, 32'h0);
        for (int i = 0; i < 8; i++) rd_chk(8'h00, 32'h0);
        wr(8'h08, 32'hFFFFFFFF);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h04, 32'h0);
        outs(3'b000);
        // enable low: the status write must be ignored
        @(posedge core_clk_i);
        ce <= 1'b0;
        wr(8'h04, 32'h3);
        @(posedge core_clk_i);
        ce <= 1'b1;
        rd_chk(8'h04, 32'h0);
        outs(3'b000);
    endtask

    task automatic t_table();
        for (int i = 0; i < 8; i++) wr(8'h00, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++) rd_chk(8'h00, 32'h7FFFFFFF);
        rd_chk(8'h00, 32'h0F0F0F0F);
        for (int i = 0; i < 3; i++) rd_chk(8'h00, 32'hFFFFFFFF);
    endtask

    task automatic t_pattern();
        mk_pat(STA, 8'hA5);
        tbl = '{32'h5, 0, 0, 0, 32'h1, 32'h0C, 0, 0};
        tbl[6] = {16'h0, crc_of(fr, 12, 31'h5)};
        load_tbl();
        wr(8'h04, 32'h2);
        st.send(fr);
        outs(3'b101);
        rd_chk(8'h04, 32'h22);
        wr(8'h04, 32'h22);
        outs(3'b001);
        mk_pat(STA, 8'hA4);
        st.send(fr);
        outs(3'b001);
        mk_pat(MCA, 8'hA5);
        st.send(fr);
        outs(3'b001);
        tbl[4] = 32'h9;
        load_tbl();
        st.send(fr);
        outs(3'b101);
        wr(8'h04, 32'h22);
        mk_pat(48'hFFFFFFFFFFFF, 8'hA5);
        st.send(fr);
        outs(3'b101);
        tbl[4] = 32'h8;
        load_tbl();
        wr(8'h04, 32'h22);
        st.send(fr);
        outs(3'b001);
        wr(8'h04, 32'h00);
        outs(3'b000);
    endtask

    task automatic t_seq();
        wr(8'h04, 32'h5);
        outs(3'b001);
        mk_seq(15);
        st.send(fr);
        outs(3'b001);
        mk_seq(16);
        st.send(fr);
        outs(3'b011);
        rd_chk(8'h04, 32'h15);
        wr(8'h04, 32'h05);
        rd_chk(8'h04, 32'h15);
        wr(8'h04, 32'h15);
        rd_chk(8'h04, 32'h05);
        wr(8'h04, 32'h00);
        outs(3'b000);
    endtask

    task automatic t_sleep();
        @(posedge core_clk_i);
        light_sleep <= 1'b1;
        outs(3'b001);
        mk_seq(16);
        st.send(fr);
        outs(3'b101);
        rd_chk(8'h04, 32'h10);
        wr(8'h04, 32'h10);
        light_sleep <= 1'b0;
        outs(3'b000);
    endtask

    initial begin
        repeat (10) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_table();
        t_pattern();
        t_seq();
        t_sleep();
        complete_run();
    end
endmodule
